// [event_log_regs.vh]
// Purpose: constants of the module event log queue
// Assumes: 40 MHz sys_clk
// Notes: entry layout, severity/response/location codes, timing
`ifndef EVENT_LOG_REGS_VH
`define EVENT_LOG_REGS_VH

// log geometry
`define LOG_DEPTH 100
`define NV_DEPTH 24
`define ENTRY_W 106

// entry field positions
`define F_DATA_LO 0
`define F_DATA_HI 31
`define F_INFO_LO 32
`define F_INFO_HI 47
`define F_ID_LO 48
`define F_ID_HI 63
`define F_RESP_LO 64
`define F_RESP_HI 65
`define F_SEV_LO 66
`define F_SEV_HI 67
`define F_LOC_LO 68
`define F_LOC_HI 71
`define F_STORED 72
`define F_VALID 73
`define F_TIME_LO 74
`define F_TIME_HI 105

// severity codes
`define SEV_INFO 2'h0
`define SEV_WARN 2'h1
`define SEV_ERROR 2'h2

// response codes
`define RESP_NONE 2'h0
`define RESP_NORMAL 2'h1
`define RESP_FAST 2'h2

// location: zero is module level, else axis number
`define LOC_MODULE 4'h0

// identifiers
`define ID_PARAM_A 16'h0446
`define ID_PARAM_B 16'h0456
`define ID_FAST_BITS 16'h6000
`define DEP_PARAM_MARK 8'h41

// timestamp tick
`define TICK_US 50
`define CLK_MHZ 40
`define TICK_CYCLES (`TICK_US * `CLK_MHZ)

`endif

// [event_skid_buffer.v]
// Purpose: two-entry buffer with valid/ready on both sides
// Assumes: single clock, async active-low reset
// Notes: all outputs registered; a stall loses no word
`timescale 1ns/1ps
module event_skid_buffer #(
    parameter WIDTH = 8
) (
    // clock and reset
    input wire sysClk,
    input wire rstN,
    // filling side
    input wire inValid,
    input wire [WIDTH-1:0] inData,
    output reg inReady_r,
    // draining side
    output reg outValid_r,
    output reg [WIDTH-1:0] outData_r,
    input wire outReady
);

reg spareValid_r;
reg [WIDTH-1:0] spareData_r;
wire pushIn = inValid && inReady_r;
wire popOut = outValid_r && outReady;

always @(posedge sysClk or negedge rstN) begin
    if (!rstN) begin
        inReady_r <= 1'b1;
        outValid_r <= 1'b0;
        outData_r <= {WIDTH{1'b0}};
        spareValid_r <= 1'b0;
        spareData_r <= {WIDTH{1'b0}};
    end else begin
        if (!outValid_r || popOut) begin
            if (spareValid_r) begin
                outValid_r <= 1'b1;
                outData_r <= spareData_r;
                spareValid_r <= 1'b0;
                inReady_r <= 1'b1;
            end else begin
                outValid_r <= pushIn;
                if (pushIn) begin
                    outData_r <= inData;
                end
            end
        end else if (pushIn) begin
            // main stalled: park word in spare
            spareValid_r <= 1'b1;
            spareData_r <= inData;
            inReady_r <= 1'b0;
        end
    end
end

endmodule

// [event_log_queue.v]
// Purpose: ordered event log of the motion_module with readout and NV save
// Assumes: external NV store, one cycle read latency; inputs synchronous
// Notes: readout oldest first, last word flagged in top bit
`timescale 1ns/1ps
`include "event_log_regs.vh"
module event_log_queue #(
    parameter DEPTH = `LOG_DEPTH,
    parameter NV_DEPTH = `NV_DEPTH,
    parameter [15:0] POWERUP_ID = 16'h0F01,
    parameter [15:0] CONFIG_ID = 16'h0F02
) (
    // clock and reset
    input wire sys_clk,
    input wire rst_n,
    // event input
    input wire evValid,
    output reg evReady_r,
    input wire [3:0] evLocation,
    input wire [1:0] evSeverity,
    input wire [15:0] evEntryIdentifier,
    input wire evFromCommand,
    input wire [15:0] commandFailureCode,
    input wire [15:0] evInfo,
    input wire [31:0] evData,
    input wire evDepParamValid,
    input wire [7:0] evDepParam,
    input wire [1:0] evResponse,
    // system events
    input wire hwConfigChanged,
    input wire powerFail,
    // log readout
    input wire logReadoutCommand,
    output wire rdValid,
    output wire [`ENTRY_W:0] rdData,
    input wire rdReady,
    // non-volatile store
    output reg nvRdEn_r,
    output reg [4:0] nvRdAddr_r,
    input wire [`ENTRY_W-1:0] nvRdData,
    output reg nvWrEn_r,
    output reg [4:0] nvWrAddr_r,
    output reg [`ENTRY_W-1:0] nvWrData_r,
    // status
    output reg [6:0] logCount_r,
    output reg readoutBusy_r,
    output reg saveDone_r
);

localparam [2:0] ST_RESTORE = 3'h0;
localparam [2:0] ST_RUN = 3'h1;
localparam [2:0] ST_DUMP = 3'h2;
localparam [2:0] ST_SAVE = 3'h3;
localparam [2:0] ST_HALT = 3'h4;
localparam integer TICK_LAST = `TICK_CYCLES - 1;

function [6:0] wrapAdd;
    input [6:0] base;
    input [6:0] off;
    reg [7:0] sum;
    begin
        sum = {1'b0, base} + {1'b0, off};
        if (sum >= DEPTH) begin
            sum = sum - DEPTH[7:0];
        end
        wrapAdd = sum[6:0];
    end
endfunction

reg [`ENTRY_W-1:0] logMem [0:DEPTH-1];
reg [2:0] state_r;
reg [6:0] head_r;
reg [11:0] tickDiv_r;
reg [31:0] timeStamp_r;
reg powerUpPend_r;
reg configPend_r;
reg [4:0] restIdx_r;
reg restDataVld_r;
reg [6:0] dumpIdx_r;
reg [4:0] saveIdx_r;
reg [6:0] saveBase_r;
reg [6:0] saveCnt_r;

////////////////////////////////////////////////////////////////////////////////
// entry build

reg [15:0] idNext;
reg [31:0] dataNext;
reg [`ENTRY_W-1:0] evEntry;
always @* begin
    idNext = evFromCommand ? commandFailureCode : evEntryIdentifier;
    if (evResponse == `RESP_FAST) begin
        idNext = idNext | `ID_FAST_BITS;
    end
    dataNext = evData;
    if (((idNext & 16'h0FFF) == `ID_PARAM_A) || ((idNext & 16'h0FFF) == `ID_PARAM_B)) begin
        if (evDepParamValid) begin
            dataNext = {8'h00, `DEP_PARAM_MARK, 8'h00, evDepParam};
        end
    end
    evEntry = {`ENTRY_W{1'b0}};
    evEntry[`F_TIME_HI:`F_TIME_LO] = timeStamp_r;
    evEntry[`F_VALID] = 1'b1;
    evEntry[`F_LOC_HI:`F_LOC_LO] = evLocation;
    evEntry[`F_SEV_HI:`F_SEV_LO] = evSeverity;
    evEntry[`F_RESP_HI:`F_RESP_LO] = evResponse;
    evEntry[`F_ID_HI:`F_ID_LO] = idNext;
    evEntry[`F_INFO_HI:`F_INFO_LO] = evInfo;
    evEntry[`F_DATA_HI:`F_DATA_LO] = dataNext;
end

////////////////////////////////////////////////////////////////////////////////
// append mux

reg appendEn;
reg [`ENTRY_W-1:0] appendData;
reg [`ENTRY_W-1:0] sysEntry;
wire evTake = evValid && evReady_r;
always @* begin
    sysEntry = {`ENTRY_W{1'b0}};
    sysEntry[`F_TIME_HI:`F_TIME_LO] = timeStamp_r;
    sysEntry[`F_VALID] = 1'b1;
    sysEntry[`F_LOC_HI:`F_LOC_LO] = `LOC_MODULE;
    sysEntry[`F_SEV_HI:`F_SEV_LO] = `SEV_INFO;
    sysEntry[`F_RESP_HI:`F_RESP_LO] = `RESP_NONE;
    sysEntry[`F_ID_HI:`F_ID_LO] = powerUpPend_r ? POWERUP_ID : CONFIG_ID;
    appendEn = 1'b0;
    appendData = evEntry;
    if (state_r == ST_RESTORE) begin
        appendEn = restDataVld_r && nvRdData[`F_VALID];
        appendData = nvRdData;
        appendData[`F_STORED] = 1'b1;
    end else if (state_r == ST_RUN) begin
        if (powerUpPend_r || configPend_r) begin
            appendEn = 1'b1;
            appendData = sysEntry;
        end else begin
            appendEn = evTake;
        end
    end
end

wire logFull = (logCount_r == DEPTH);
wire [6:0] wrPtr = wrapAdd(head_r, logCount_r);

always @(posedge sys_clk) begin
    if (appendEn) begin
        logMem[wrPtr] <= appendData;
    end
end

////////////////////////////////////////////////////////////////////////////////
// readout through buffer

wire skidReady;
wire dumpPush = (state_r == ST_DUMP) && skidReady;
wire dumpLast = (dumpIdx_r == logCount_r - 7'h01);
wire [`ENTRY_W-1:0] dumpEntry = logMem[wrapAdd(head_r, dumpIdx_r)];

event_skid_buffer #(
    .WIDTH(`ENTRY_W + 1)
) readBuf (
    .sysClk(sys_clk),
    .rstN(rst_n),
    .inValid(dumpPush),
    .inData({dumpLast, dumpEntry}),
    .inReady_r(skidReady),
    .outValid_r(rdValid),
    .outData_r(rdData),
    .outReady(rdReady)
);

////////////////////////////////////////////////////////////////////////////////
// control

wire [6:0] saveN = (logCount_r > NV_DEPTH) ? NV_DEPTH[6:0] : logCount_r;
wire [4:0] saveSlot = saveIdx_r;
wire [`ENTRY_W-1:0] saveEntry = logMem[wrapAdd(saveBase_r, {2'b00, saveIdx_r})];

always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        state_r <= ST_RESTORE;
        head_r <= 7'h00;
        logCount_r <= 7'h00;
        tickDiv_r <= 12'h000;
        timeStamp_r <= 32'h0000_0000;
        powerUpPend_r <= 1'b1;
        configPend_r <= 1'b0;
        restIdx_r <= 5'h00;
        restDataVld_r <= 1'b0;
        dumpIdx_r <= 7'h00;
        saveIdx_r <= 5'h00;
        saveBase_r <= 7'h00;
        saveCnt_r <= 7'h00;
        evReady_r <= 1'b0;
        nvRdEn_r <= 1'b0;
        nvRdAddr_r <= 5'h00;
        nvWrEn_r <= 1'b0;
        nvWrAddr_r <= 5'h00;
        nvWrData_r <= {`ENTRY_W{1'b0}};
        readoutBusy_r <= 1'b0;
        saveDone_r <= 1'b0;
    end else begin
        if (tickDiv_r == TICK_LAST) begin
            tickDiv_r <= 12'h000;
            timeStamp_r <= timeStamp_r + 32'h0000_0001;
        end else begin
            tickDiv_r <= tickDiv_r + 12'h001;
        end
        if (appendEn) begin
            if (logFull) begin
                head_r <= wrapAdd(head_r, 7'h01);
            end else begin
                logCount_r <= logCount_r + 7'h01;
            end
        end
        // config change held; a new change wins over the clear
        if (hwConfigChanged) begin
            configPend_r <= 1'b1;
        end else if (appendEn && (state_r == ST_RUN) && !powerUpPend_r && configPend_r) begin
            configPend_r <= 1'b0;
        end
        if (appendEn && (state_r == ST_RUN) && powerUpPend_r) begin
            powerUpPend_r <= 1'b0;
        end
        nvWrEn_r <= 1'b0;
        nvRdEn_r <= 1'b0;
        evReady_r <= 1'b0;
        case (state_r)
            ST_RESTORE: begin
                restDataVld_r <= nvRdEn_r;
                if (restIdx_r < NV_DEPTH) begin
                    nvRdEn_r <= 1'b1;
                    nvRdAddr_r <= restIdx_r;
                    restIdx_r <= restIdx_r + 5'h01;
                end else if (!nvRdEn_r && !restDataVld_r) begin
                    state_r <= ST_RUN;
                end
            end
            ST_RUN: begin
                evReady_r <= !powerFail && !logReadoutCommand && !hwConfigChanged && !configPend_r
                    && !powerUpPend_r && !(appendEn && !evTake);
                if (powerFail) begin
                    state_r <= ST_SAVE;
                    saveIdx_r <= 5'h00;
                    saveCnt_r <= saveN;
                    saveBase_r <= wrapAdd(head_r, logCount_r - saveN);
                end else if (logReadoutCommand && !appendEn && (logCount_r != 7'h00)) begin
                    state_r <= ST_DUMP;
                    dumpIdx_r <= 7'h00;
                    readoutBusy_r <= 1'b1;
                end
            end
            ST_DUMP: begin
                if (powerFail) begin
                    state_r <= ST_RUN;
                    readoutBusy_r <= 1'b0;
                end else if (dumpPush) begin
                    if (dumpLast) begin
                        state_r <= ST_RUN;
                        readoutBusy_r <= 1'b0;
                    end else begin
                        dumpIdx_r <= dumpIdx_r + 7'h01;
                    end
                end
            end
            ST_SAVE: begin
                nvWrEn_r <= 1'b1;
                nvWrAddr_r <= saveSlot;
                nvWrData_r <= ({2'b00, saveIdx_r} < saveCnt_r) ? saveEntry : {`ENTRY_W{1'b0}};
                if (saveIdx_r == NV_DEPTH - 1) begin
                    state_r <= ST_HALT;
                end else begin
                    saveIdx_r <= saveIdx_r + 5'h01;
                end
            end
            ST_HALT: begin
                saveDone_r <= 1'b1;
            end
            default: begin
                state_r <= ST_RUN;
            end
        endcase
    end
end

endmodule

// [event_log_queue_monitor.sv]
// Purpose: port checker of the event log queue
// Assumes: one clock, async active-low reset
// Notes: bound to every event_log_queue instance
`timescale 1ns/1ps
`include "event_log_regs.vh"
module event_log_queue_checker #(
    parameter DEPTH = `LOG_DEPTH
) (
    // clock and reset
    input wire sys_clk,
    input wire rst_n,
    // event side
    input wire evValid,
    input wire evReady_r,
    input wire [6:0] logCount_r,
    // readout side
    input wire rdValid,
    input wire [`ENTRY_W:0] rdData,
    input wire rdReady,
    input wire readoutBusy_r,
    // nv store
    input wire nvWrEn_r,
    input wire [4:0] nvWrAddr_r
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    AST_COUNT_MAX: assert property (logCount_r <= DEPTH)
        else $error("log count above depth");
    AST_TAKE_INC: assert property (evValid && evReady_r && logCount_r < DEPTH
        |=> logCount_r == $past(logCount_r) + 7'h01) else $error("taken event not counted");
    AST_FULL_DROP: assert property (evValid && evReady_r && logCount_r == DEPTH
        |=> logCount_r == DEPTH) else $error("full log count changed");
    AST_NVW_FIRST: assert property ($rose(nvWrEn_r) |-> nvWrAddr_r == 5'h00)
        else $error("save not started at slot zero");
    AST_NVW_SEQ: assert property (nvWrEn_r && nvWrAddr_r != 5'h17
        |=> nvWrEn_r && nvWrAddr_r == $past(nvWrAddr_r) + 5'h01) else $error("save sequence broken");
    AST_RD_HOLD: assert property (rdValid && !rdReady |=> rdValid && $stable(rdData))
        else $error("readout word not held");
    AST_BUSY_REFUSE: assert property (readoutBusy_r |-> !evReady_r)
        else $error("event accepted during readout");
    AST_FAST_ID: assert property (rdValid && rdData[65:64] == `RESP_FAST |-> rdData[62:61] == 2'h3)
        else $error("fast stop id lacks fast bits");
endmodule
////////////////////
bind event_log_queue event_log_queue_checker #(.DEPTH(DEPTH)) i_chk (.sys_clk, .rst_n, .evValid, .evReady_r,
    .logCount_r, .rdValid, .rdData, .rdReady, .readoutBusy_r, .nvWrEn_r, .nvWrAddr_r);

// [nv_host_model.sv]
// Purpose: nv store and readout host beside the log queue
// Assumes: nv read data one cycle after strobe
// Notes: store keeps contents across the queue's reset
`timescale 1ns/1ps
`include "event_log_regs.vh"
module nv_host_model #(
    parameter [`ENTRY_W-1:0] PRESET = 106'h0
) (
    // clock and pacing
    input wire sys_clk,
    input wire slow,
    // nv store
    input wire nvRdEn_r,
    input wire [4:0] nvRdAddr_r,
    output reg [`ENTRY_W-1:0] nvRdData,
    input wire nvWrEn_r,
    input wire [4:0] nvWrAddr_r,
    input wire [`ENTRY_W-1:0] nvWrData_r,
    // readout
    output reg rdReady
);
    reg [`ENTRY_W-1:0] mem [0:23];
    reg [1:0] pace_r;
    integer i;
    initial begin
        for (i = 1; i < 24; i = i + 1) mem[i] = 106'h0;
        mem[0] = PRESET;
        nvRdData = 106'h0;
        rdReady = 1'b0;
        pace_r = 2'h0;
    end
    always @(posedge sys_clk) begin
        pace_r <= pace_r + 2'h1;
        rdReady <= !slow || pace_r == 2'h0;
        nvRdData <= nvRdEn_r ? mem[nvRdAddr_r] : ~nvRdData;
        if (nvWrEn_r) mem[nvWrAddr_r] <= nvWrData_r;
    end
endmodule

// [testbench.sv]
// Purpose: self-checking bench of the event log queue
// Assumes: 40 MHz clock, queue model in the bench
// Notes: time field masked except where predictable
`timescale 1ns/1ps
`include "event_log_regs.vh"
module testbench;
    localparam [`ENTRY_W-1:0] PRESET = {32'h10, 2'h2, 4'h3, `SEV_WARN, `RESP_NORMAL, 32'h0321_1234, 32'hCAFE0001};
    localparam [`ENTRY_W-1:0] TM = {32'h0, {74{1'b1}}};
    localparam [`ENTRY_W-1:0] SM = {{32{1'b1}}, 26'h3FFFFFF, 48'h0};
    localparam [`ENTRY_W-1:0] ST = {33'h0, 1'b1, 72'h0};
    reg sys_clk, rst_n, evValid, evFromCommand, evDepParamValid, hwConfigChanged, powerFail, logReadoutCommand, slow;
    reg [3:0] evLocation;
    reg [1:0] evSeverity, evResponse;
    reg [15:0] evEntryIdentifier, commandFailureCode, evInfo;
    reg [31:0] evData;
    reg [7:0] evDepParam;
    wire evReady_r, rdValid, rdReady, nvRdEn_r, nvWrEn_r, readoutBusy_r, saveDone_r;
    wire [`ENTRY_W:0] rdData;
    wire [4:0] nvRdAddr_r, nvWrAddr_r;
    wire [`ENTRY_W-1:0] nvRdData, nvWrData_r;
    wire [6:0] logCount_r;
    reg [`ENTRY_W-1:0] expQ[$], mskQ[$];
    integer mismatches = 0, compares = 0, cyc = 0, tmo = 0, k;
    event_log_queue i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .evValid(evValid), .evReady_r(evReady_r),
        .evLocation(evLocation), .evSeverity(evSeverity), .evEntryIdentifier(evEntryIdentifier),
        .evFromCommand(evFromCommand), .commandFailureCode(commandFailureCode), .evInfo(evInfo),
        .evData(evData), .evDepParamValid(evDepParamValid), .evDepParam(evDepParam), .evResponse(evResponse),
        .hwConfigChanged(hwConfigChanged), .powerFail(powerFail), .logReadoutCommand(logReadoutCommand),
        .rdValid(rdValid), .rdData(rdData), .rdReady(rdReady), .nvRdEn_r(nvRdEn_r), .nvRdAddr_r(nvRdAddr_r),
        .nvRdData(nvRdData), .nvWrEn_r(nvWrEn_r), .nvWrAddr_r(nvWrAddr_r), .nvWrData_r(nvWrData_r),
        .logCount_r(logCount_r), .readoutBusy_r(readoutBusy_r), .saveDone_r(saveDone_r));
    nv_host_model #(.PRESET(PRESET)) i_nv (.sys_clk(sys_clk), .slow(slow), .nvRdEn_r(nvRdEn_r),
        .nvRdAddr_r(nvRdAddr_r), .nvRdData(nvRdData), .nvWrEn_r(nvWrEn_r), .nvWrAddr_r(nvWrAddr_r),
        .nvWrData_r(nvWrData_r), .rdReady(rdReady));
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= rst_n ? cyc + 1 : 0;
        tmo = tmo + 1;
        if (tmo == 20000) begin
            mismatches = mismatches + 1;
            end_of_test;
        end
    end
    ////////////////////
    task chk(input string nm, input [`ENTRY_W:0] seen, input [`ENTRY_W:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task push(input [`ENTRY_W-1:0] e, input [`ENTRY_W-1:0] m);
        if (expQ.size() == 100) begin
            void'(expQ.pop_front());
            void'(mskQ.pop_front());
        end
        expQ.push_back(e & m);
        mskQ.push_back(m);
    endtask
    task settle;
        while (logCount_r !== expQ.size()) @(posedge sys_clk);
    endtask
    task send_ev;
        reg [31:0] a, b, dt;
        reg [1:0] sv, rs;
        reg [15:0] id;
        a = $urandom;
        b = $urandom;
        dt = $urandom;
        sv = (a[1:0] == 2'h3) ? `SEV_INFO : a[1:0];
        rs = (a[3:2] == 2'h3) ? `RESP_FAST : a[3:2];
        id = (a[5:4] == 2'h0) ? `ID_PARAM_A : (a[5:4] == 2'h1) ? `ID_PARAM_B : {4'h0, b[11:0]};
        evLocation <= a[9:6];
        evSeverity <= sv;
        evResponse <= rs;
        evFromCommand <= a[10];
        evEntryIdentifier <= a[10] ? b[31:16] : id;
        commandFailureCode <= a[10] ? id : b[31:16];
        evInfo <= a[31:16];
        evData <= dt;
        evDepParamValid <= a[11];
        evDepParam <= b[19:12];
        evValid <= 1'b1;
        if (rs == `RESP_FAST) id = id | `ID_FAST_BITS;
        if ((id[11:0] == 12'h446 || id[11:0] == 12'h456) && a[11]) dt = {16'h0041, 8'h00, b[19:12]};
        @(posedge sys_clk);
        while (evReady_r !== 1'b1) @(posedge sys_clk);
        push({32'h0, 2'h2, a[9:6], sv, rs, id, a[31:16], dt}, TM);
    endtask
    task readout;
        integer i;
        reg [31:0] lastT;
        logReadoutCommand <= 1'b1;
        @(posedge sys_clk);
        logReadoutCommand <= 1'b0;
        i = 0;
        lastT = 0;
        while (i < expQ.size()) begin
            @(posedge sys_clk);
            if (rdValid === 1'b1 && rdReady === 1'b1) begin
                chk("entry", rdData[`ENTRY_W-1:0] & mskQ[i], expQ[i]);
                chk("last", rdData[`ENTRY_W], i == expQ.size() - 1);
                if (!rdData[72]) begin
                    chk("time order", rdData[105:74] < lastT, 0);
                    lastT = rdData[105:74];
                end
                i = i + 1;
            end
        end
    endtask
    task end_of_test;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////
    initial begin
        void'($urandom(73));
        {evValid, evFromCommand, evDepParamValid, hwConfigChanged, powerFail, logReadoutCommand, slow} = 7'h00;
        {evLocation, evSeverity, evResponse, evEntryIdentifier, commandFailureCode, evInfo, evData, evDepParam} = 0;
        rst_n = 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        push(PRESET | ST, {`ENTRY_W{1'b1}});
        push({32'h0, 2'h2, 4'h0, `SEV_INFO, `RESP_NONE, 16'h0F01, 16'h0, 32'h0}, SM);
        settle;
        repeat (30) send_ev;
        evValid <= 1'b0;
        while (cyc < 5000) @(posedge sys_clk);
        hwConfigChanged <= 1'b1;
        @(posedge sys_clk);
        hwConfigChanged <= 1'b0;
        push({32'h2, 2'h2, 4'h0, `SEV_INFO, `RESP_NONE, 16'h0F02, 16'h0, 32'h0}, SM);
        settle;
        slow <= 1'b1;
        readout;
        repeat (80) send_ev;
        evValid <= 1'b0;
        settle;
        chk("count", logCount_r, 100);
        slow <= 1'b0;
        readout;
        powerFail <= 1'b1;
        @(posedge sys_clk);
        powerFail <= 1'b0;
        while (saveDone_r !== 1'b1) @(posedge sys_clk);
        for (k = 0; k < 24; k = k + 1) chk("saved", i_nv.mem[k] & mskQ[76 + k], expQ[76 + k]);
        rst_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        while (expQ.size() > 24) begin
            void'(expQ.pop_front());
            void'(mskQ.pop_front());
        end
        for (k = 0; k < 24; k = k + 1) push(expQ.pop_front() | ST, mskQ.pop_front());
        push({32'h0, 2'h2, 4'h0, `SEV_INFO, `RESP_NONE, 16'h0F01, 16'h0, 32'h0}, SM);
        settle;
        readout;
        end_of_test;
    end
endmodule
